// ### hw/dram_ctl_defines.vh
`ifndef DRAM_CTL_DEFINES_VH
`define DRAM_CTL_DEFINES_VH
`define CLK_PERIOD_NS 10
`define ADDR_W 12
`define ROW_W 6
`define ROW_COUNT 64
`define REFRESH_INTERVAL_NS 2000000
`define STROBE_ON_NS 350
`define STROBE_OFF_NS 200
`define ADDR_HOLD_NS 100
`define ACCESS_NS 300
`define WE_DELAY_NS 150
`define WE_PULSE_NS 100
`define RMW_CYCLE_PERIOD_NS 750
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)
`endif

// ### hw/pin_sync.v
`timescale 1ns/1ps
module pin_sync (
   input wire mclk,
   input wire rst_n,
   input wire din,
   output reg dout
);
   reg meta_reg;
   always @(posedge mclk) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule // pin_sync

// ### hw/dram_host.v
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
module dram_host #(
   parameter REFRESH_CYCLES = `CYC_DN(`REFRESH_INTERVAL_NS / `ROW_COUNT)
) (
   input wire mclk,
   input wire rst_n,
   input wire req_valid,
   input wire req_write,
   input wire req_rmw,
   input wire req_invert,
   input wire [11:0] req_addr,
   input wire req_wdata,
   output reg req_ready,
   output reg resp_valid,
   output reg resp_rdata,
   output reg dram_strobe,
   output reg [11:0] dram_addr,
   output reg dram_cs_n,
   output reg dram_we_n,
   output reg dram_din,
   input wire dram_dout
);
   // Sequencer states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ON = 3'h1;
   localparam [2:0] ST_RMW_WE = 3'h2;
   localparam [2:0] ST_OFF = 3'h3;
   localparam [2:0] ST_PAD = 3'h4;
   // Phase lengths in clock cycles
   localparam integer ON_CYC = `CYC_UP(`STROBE_ON_NS);
   localparam integer OFF_CYC = `CYC_UP(`STROBE_OFF_NS);
   localparam integer ACC_CYC = `CYC_UP(`ACCESS_NS) + 2;
   localparam integer WED_CYC = `CYC_UP(`WE_DELAY_NS);
   localparam integer WEP_CYC = `CYC_UP(`WE_PULSE_NS);
   localparam integer RMW_CYC = `CYC_UP(`RMW_CYCLE_PERIOD_NS);
   // Slot two cycles short, so a delayed refresh never overruns the interval
   localparam integer SLOT_CYC = REFRESH_CYCLES - 2;
   localparam [15:0] N_ON = ON_CYC[15:0];
   localparam [15:0] N_OFF = OFF_CYC[15:0];
   localparam [15:0] N_ACC = ACC_CYC[15:0];
   localparam [15:0] N_WED = WED_CYC[15:0];
   localparam [15:0] N_WEP = WEP_CYC[15:0];
   localparam [15:0] N_RMW = RMW_CYC[15:0];
   localparam [31:0] REF_LAST = SLOT_CYC - 1;
   // Sequencer registers and their next values
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [15:0] cnt_reg;
   reg [15:0] cnt_next;
   reg [15:0] per_reg;
   reg [15:0] per_next;
   reg [31:0] ref_cnt_reg;
   reg ref_pend_reg;
   reg ref_pend_next;
   reg [5:0] row_reg;
   reg [5:0] row_next;
   reg is_ref_reg;
   reg is_ref_next;
   reg is_wr_reg;
   reg is_wr_next;
   reg is_rmw_reg;
   reg is_rmw_next;
   reg inv_reg;
   reg inv_next;
   // Next values of the registered outputs
   reg ready_next;
   reg resp_valid_next;
   reg resp_rdata_next;
   reg strobe_next;
   reg [11:0] addr_next;
   reg cs_n_next;
   reg we_n_next;
   reg din_next;
   wire dout_s;
   wire ref_due;

   // Data out pin crosses two flops
   pin_sync u_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din(dram_dout),
      .dout(dout_s)
   );

   // Last cycle of a phase
   function at_end;
      input [15:0] cnt;
      input [15:0] len;
      begin
         at_end = (cnt == len - 16'h0001);
      end
   endfunction

   // Row refresh timer; one row per slot spreads 64 rows over the interval
   assign ref_due = (ref_cnt_reg >= REF_LAST);
   always @(posedge mclk) begin
      if (!rst_n) begin
         ref_cnt_reg <= 32'h00000000;
      end else if (ref_due) begin
         ref_cnt_reg <= 32'h00000000;
      end else begin
         ref_cnt_reg <= ref_cnt_reg + 32'h00000001;
      end
   end

   // Next state and next output values
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg + 16'h0001;
      per_next = per_reg;
      ref_pend_next = ref_pend_reg;
      row_next = row_reg;
      is_ref_next = is_ref_reg;
      is_wr_next = is_wr_reg;
      is_rmw_next = is_rmw_reg;
      inv_next = inv_reg;
      ready_next = 1'h0;
      resp_valid_next = 1'h0;
      resp_rdata_next = resp_rdata;
      strobe_next = dram_strobe;
      addr_next = dram_addr;
      cs_n_next = dram_cs_n;
      we_n_next = dram_we_n;
      din_next = dram_din;
      // Spacing timer between cycle starts
      if (per_reg != 16'h0000) begin
         per_next = per_reg - 16'h0001;
      end
      case (state_reg)
         ST_IDLE: begin
            cnt_next = 16'h0000;
            we_n_next = 1'h1;
            if (ref_pend_reg) begin
               // Refresh read, deselected, row in low address bits
               ref_pend_next = 1'h0;
               is_ref_next = 1'h1;
               is_wr_next = 1'h0;
               is_rmw_next = 1'h0;
               addr_next = {6'h00, row_reg};
               cs_n_next = 1'h1;
               row_next = row_reg + 6'h01;
               strobe_next = 1'h1;
               state_next = ST_ON;
            end else if (req_valid && req_ready) begin
               is_ref_next = 1'h0;
               is_wr_next = req_write & ~req_rmw;
               is_rmw_next = req_rmw;
               inv_next = req_invert;
               addr_next = req_addr;
               cs_n_next = 1'h0;
               din_next = req_wdata;
               we_n_next = ~(req_write & ~req_rmw);
               strobe_next = 1'h1;
               per_next = N_RMW;
               state_next = ST_ON;
            end else begin
               // Ready only when no refresh can win the next edge
               ready_next = !ref_due;
            end
         end
         ST_ON: begin
            if (is_rmw_reg) begin
               // Write strobe held high until data out valid
               if (at_end(cnt_reg, N_ACC)) begin
                  din_next = dout_s ^ inv_reg;
                  resp_rdata_next = dout_s;
                  cnt_next = 16'h0000;
                  state_next = ST_RMW_WE;
               end
            end else if (at_end(cnt_reg, N_ON)) begin
               if (!is_wr_reg && !is_ref_reg) begin
                  resp_rdata_next = dout_s;
                  resp_valid_next = 1'h1;
               end
               if (is_wr_reg) begin
                  resp_valid_next = 1'h1;
               end
               strobe_next = 1'h0;
               we_n_next = 1'h1;
               cnt_next = 16'h0000;
               state_next = ST_OFF;
            end
         end
         ST_RMW_WE: begin
            if (cnt_reg == 16'h0000) begin
               we_n_next = 1'h0;
            end
            if (cnt_reg >= N_WEP && cnt_reg >= N_WED) begin
               // Strobe width stays far below 4000 ns
               strobe_next = 1'h0;
               we_n_next = 1'h1;
               resp_valid_next = 1'h1;
               cnt_next = 16'h0000;
               state_next = ST_OFF;
            end
         end
         ST_OFF: begin
            if (at_end(cnt_reg, N_OFF)) begin
               state_next = ST_PAD;
            end
         end
         ST_PAD: begin
            if (per_reg == 16'h0000) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // A new refresh slot wins over the clear of the old one
      if (ref_due) begin
         ref_pend_next = 1'h1;
      end
   end

   // Sequencer registers
   always @(posedge mclk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 16'h0000;
         per_reg <= 16'h0000;
         ref_pend_reg <= 1'h0;
         row_reg <= 6'h00;
         is_ref_reg <= 1'h0;
         is_wr_reg <= 1'h0;
         is_rmw_reg <= 1'h0;
         inv_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         per_reg <= per_next;
         ref_pend_reg <= ref_pend_next;
         row_reg <= row_next;
         is_ref_reg <= is_ref_next;
         is_wr_reg <= is_wr_next;
         is_rmw_reg <= is_rmw_next;
         inv_reg <= inv_next;
      end
   end

   // Every output straight from a flip-flop
   always @(posedge mclk) begin
      if (!rst_n) begin
         req_ready <= 1'h0;
         resp_valid <= 1'h0;
         resp_rdata <= 1'h0;
         dram_strobe <= 1'h0;
         dram_addr <= 12'h000;
         dram_cs_n <= 1'h1;
         dram_we_n <= 1'h1;
         dram_din <= 1'h0;
      end else begin
         req_ready <= ready_next;
         resp_valid <= resp_valid_next;
         resp_rdata <= resp_rdata_next;
         dram_strobe <= strobe_next;
         dram_addr <= addr_next;
         dram_cs_n <= cs_n_next;
         dram_we_n <= we_n_next;
         dram_din <= din_next;
      end
   end
endmodule // dram_host

// ### verif/dram_host_checker.sv
`timescale 1ns/1ps
module dram_host_checker #(parameter REFRESH_CYCLES = 3125) (
   input wire mclk,
   input wire rst_n,
   input wire dram_strobe,
   input wire [11:0] dram_addr,
   input wire dram_cs_n,
   input wire dram_we_n,
   input wire dram_din
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   int son, gap, rgap;
   reg [5:0] lrow;
   reg seen;
   wire rf = dram_strobe && dram_cs_n;
   always @(posedge mclk) begin
      son <= (rst_n && dram_strobe) ? son + 32'h1 : 32'h0;
      gap <= !rst_n ? 32'h3E7 : $rose(dram_strobe) ? 32'h1 : gap + 32'h1;
      rgap <= (!rst_n || $rose(dram_strobe) && rf) ? 32'h0 : rgap + 32'h1;
      seen <= rst_n && (seen || $rose(dram_strobe) && rf);
      if ($rose(dram_strobe) && rf) lrow <= dram_addr[5:0];
   end
   property p_row; $rose(dram_strobe) && rf && seen |-> dram_addr[5:0] == lrow + 6'h1; endproperty
   a_row: assert property (p_row) else $error("refresh row skipped");
   property p_rint; rgap < REFRESH_CYCLES + 100; endproperty
   a_rint: assert property (p_rint) else $error("refresh late");
   property p_gap; $rose(dram_strobe) |-> gap >= 52; endproperty
   a_gap: assert property (p_gap) else $error("cycle starts too close");
   property p_width; $fell(dram_strobe) |-> son >= 35 && son <= 400; endproperty
   a_width: assert property (p_width) else $error("strobe width wrong");
   property p_early; dram_strobe && !dram_we_n && !$rose(dram_strobe) |-> $stable(dram_din); endproperty
   a_early: assert property (p_early) else $error("data moved in write");
   property p_late; $fell(dram_we_n) && !$rose(dram_strobe) |-> son >= 30; endproperty
   a_late: assert property (p_late) else $error("write before data out");
   property p_wsel; !dram_we_n |-> dram_strobe && !dram_cs_n; endproperty
   a_wsel: assert property (p_wsel) else $error("write strobe outside cycle");
   c_rmw: cover property ($fell(dram_we_n) && !$rose(dram_strobe));
   c_ref: cover property ($rose(dram_strobe) && rf);
   c_early: cover property ($rose(dram_strobe) && !dram_we_n);
endmodule // dram_host_checker
bind dram_host dram_host_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.mclk, .rst_n,
   .dram_strobe, .dram_addr, .dram_cs_n, .dram_we_n, .dram_din);

// ### verif/dram_model.sv
`timescale 1ns/1ps
module dram_model #(parameter ACC = 28) (
   input wire mclk,
   input wire dram_strobe,
   input wire [11:0] dram_addr,
   input wire dram_cs_n,
   input wire dram_we_n,
   input wire dram_din,
   output wire dram_dout
);
   reg mem [0:4095];
   reg [11:0] la = 12'h0;
   reg lc = 1'h1;
   reg last = 1'h0;
   int on = 0;
   wire [11:0] a = on == 0 ? dram_addr : la;
   wire sel = on == 0 ? !dram_cs_n : !lc;
   wire drv = dram_strobe && !lc && on >= ACC;
   assign dram_dout = drv ? mem[la] : ~last;
   always @(posedge mclk) begin
      on <= dram_strobe ? on + 1 : 0;
      if (dram_strobe && on == 0) begin
         la <= dram_addr;
         lc <= dram_cs_n;
      end
      if (drv) last <= mem[la];
      if (dram_strobe && !dram_we_n && sel) mem[a] <= dram_din;
   end
endmodule // dram_model

// ### verif/tb_dram_host.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb_dram_host;
   reg mclk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0, req_rmw = 1'h0;
   reg req_invert = 1'h0, req_wdata = 1'h0, s_d = 1'h0, q;
   reg [11:0] req_addr = 12'h0;
   wire req_ready, resp_valid, resp_rdata, dram_strobe, dram_cs_n, dram_we_n;
   wire dram_din, dram_dout;
   wire [11:0] dram_addr;
   int errors = 0, samples_checked = 0, nref = 0, n;
   always #5 mclk = ~mclk;
   dram_host #(.REFRESH_CYCLES(100)) DUT (.mclk, .rst_n, .req_valid, .req_write, .req_rmw,
      .req_invert, .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_rdata, .dram_strobe,
      .dram_addr, .dram_cs_n, .dram_we_n, .dram_din, .dram_dout);
   dram_model mem (.mclk, .dram_strobe, .dram_addr, .dram_cs_n, .dram_we_n, .dram_din,
      .dram_dout);
   always @(posedge mclk) begin
      nref <= nref + (dram_strobe && !s_d && dram_cs_n);
      s_d <= dram_strobe;
   end
   task tick;
      @(posedge mclk) #1;
   endtask
   task automatic req(input w, m, v, input [11:0] a, input d);
      int i;
      for (i = 0; req_ready !== 1'h1 && i < 300; i++) tick;
      `CHK(req_ready, 1'h1)
      {req_valid, req_write, req_rmw, req_invert, req_addr, req_wdata} = {1'h1, w, m, v, a, d};
      tick;
      req_valid = 1'h0;
      for (i = 0; resp_valid !== 1'h1 && i < 300; i++) tick;
      `CHK(resp_valid, 1'h1)
      q = resp_rdata;
   endtask
   task t_rw;
      req(1'h1, 1'h0, 1'h0, 12'hFFF, 1'h1);
      req(1'h1, 1'h0, 1'h0, 12'h000, 1'h0);
      req(1'h0, 1'h0, 1'h0, 12'hFFF, 1'h0);
      `CHK(q, 1'h1)
      req(1'h0, 1'h0, 1'h0, 12'h000, 1'h1);
      `CHK(q, 1'h0)
   endtask
   task t_rmw;
      req(1'h1, 1'h1, 1'h1, 12'hFFF, 1'h1);
      `CHK(q, 1'h1)
      req(1'h0, 1'h0, 1'h0, 12'hFFF, 1'h1);
      `CHK(q, 1'h0)
      req(1'h0, 1'h1, 1'h0, 12'h000, 1'h1);
      req(1'h0, 1'h0, 1'h0, 12'h000, 1'h1);
      `CHK(q, 1'h0)
   endtask
   task t_refresh;
      n = nref;
      repeat (6400) tick;
      `CHK(nref - n >= 63, 1'h1)
   endtask
   task end_of_test;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      #1 rst_n = 1'h1;
      t_rw;
      t_rmw;
      t_refresh;
      end_of_test;
   end
   initial begin
      #200000;
      errors++;
      end_of_test;
   end
endmodule // tb_dram_host
